// ===== hdl/otc_regs.svh
// Register map constants for the overhead terminator control registers.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef OTC_REGS_SVH
`define OTC_REGS_SVH

// Printed offsets are not all multiples of four: they are indices, byte address is four times
`define OTC_IDX_LINE_MODE      9'h0fa
`define OTC_IDX_TX_OH_SRC      9'h1f8
`define OTC_IDX_PAYLOAD_MODE   9'h1fa
`define OTC_ADDR_LINE_MODE     12'h3e8
`define OTC_ADDR_TX_OH_SRC     12'h7e0
`define OTC_ADDR_PAYLOAD_MODE  12'h7e8
`define OTC_ADDR_ALARM_STATUS  12'h800

// Reset values (not documented; all clear)
`define OTC_RST_LINE_MODE      8'h00
`define OTC_RST_TX_OH_SRC      8'h00
`define OTC_RST_PAYLOAD_MODE   8'h00

// Field positions, line mode register
`define OTC_B_LINE_RATE        7
`define OTC_B_TERM_PAR         6
`define OTC_B_HW_IRQ_EN        5
`define OTC_B_RFI_INS_EN       4
`define OTC_B_ALT_OW           3
`define OTC_B_TRANS_IRQ_EN     2
`define OTC_B_PATH_IRQ_EN      1
`define OTC_B_BOTH_EDGES       0

// Field positions, tx overhead source register
`define OTC_B_SDCC_PORT        7
`define OTC_B_LDCC_PORT        6
`define OTC_B_SOW_PORT         5
`define OTC_B_LOW_PORT         4
`define OTC_B_PATH_RAM         3
`define OTC_B_APS_RAM          2
`define OTC_B_APS_CAPTURE      1
`define OTC_B_LOOPBACK         0

// Field positions, payload mode register
`define OTC_B_PAYLOAD_ONLY     7
`define OTC_B_RX_RETIME        1

`endif

// ===== hdl/otc_pkg.sv
// Types for the overhead terminator control registers.
// Assumes the register header is compiled alongside.
package otc_pkg;

	// Source of a transmitted overhead group
	typedef enum logic [1:0] {
		OTC_SRC_TERMINAL,
		OTC_SRC_PORT,
		OTC_SRC_RAM
	} otc_src_t;

	// Transport-layer events
	typedef struct packed {
		logic       rx_loss_signal;
		logic       rx_out_of_frame;
		logic       rx_loss_frame;
		logic       rx_line_alarm_ind;
		logic       rx_remote_failure;
		logic       rx_path_alarm_ind;
		logic       rx_loss_pointer;
		logic [3:0] b1b2_overflow;
		logic [5:0] new_toh_byte;
	} otc_transport_ev_t;

	// Path-layer events
	typedef struct packed {
		logic       path_yellow;
		logic [2:0] b3_febe_overflow;
		logic [4:0] new_poh_byte;
	} otc_path_ev_t;

	// Decoded controls toward the datapath
	typedef struct packed {
		logic     scramble_en;
		logic     b1_recalc;
		logic     b1_error_mask;
		logic     terminal_parallel;
		logic     rx_serial_active;
		logic     ferf_insert;
		logic     alt_orderwire_frame;
		otc_src_t sdcc_src;
		otc_src_t ldcc_src;
		otc_src_t sow_src;
		otc_src_t low_src;
		otc_src_t path_src;
		otc_src_t aps_src;
		logic     h4_from_terminal;
		logic     aps_capture;
		logic     rx_to_tx_loopback;
	} otc_ctrl_t;

	// All registered state of the block
	typedef struct packed {
		logic [7:0]        line_mode;
		logic [7:0]        tx_src;
		logic [7:0]        payload;
		otc_transport_ev_t trans_s1;
		otc_transport_ev_t trans_s2;
		otc_transport_ev_t trans_prev;
		otc_path_ev_t      path_s1;
		otc_path_ev_t      path_s2;
		otc_path_ev_t      path_prev;
		logic              trans_pend;
		logic              path_pend;
		logic              los_s1;
		logic              los_s2;
		logic              irq;
		logic              trans_irq;
		logic              path_irq;
		otc_ctrl_t         ctrl;
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
	} otc_state_t;

endpackage

// ===== hdl/otc_ctrl_regs.sv
// Control register bank of a line overhead terminator, with APB slave.
// Assumes alarm and event inputs come from other clock domains or pins,
// so each passes a two-stage synchroniser before use.
//
// Summary of operation
// R01: Line rate high: scramble, BIP-8, recalc B1
// R02: Line rate low: no scramble, error mask
// R03: Parallel select; rx serial stays active
// R04: Hardware interrupt only when enabled
// R05: Insert remote failure only when enabled
// R06: Remote failure on LOS, LOF, line AIS
// R07: Orderwire frame leads MSB or coincides
// R08: Transport interrupt only when enabled
// R09: Seven transport alarms trigger interrupt
// R10: Counter overflows, new bytes trigger too
// R11: Path interrupt only when enabled
// R12: Yellow, overflows, new path bytes trigger
// R13: Rising edge only, or both edges
// R14: Section datacom from port or terminal
// R15: Line datacom from port or terminal
// R16: E1 from orderwire port or terminal
// R17: E2 from orderwire port or terminal
// R18: Path overhead from RAM; H4 passes
// R19: APS from RAM or terminal
// R20: Copy APS to RAM each frame
// R21: Receive-to-transmit terminal loopback
// R22: Payload-only forbids terminal overhead sources; path overhead still takes terminal when its RAM bit is low
// R23: APS has three selectable sources
// R24: Payload-only needs retiming bit low
// R25: Registers are eight-bit read/write

`include "otc_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module otc_ctrl_regs (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic                            pready,
	output logic                            pslverr,
	output logic [31:0]                     prdata,
	input  wire otc_pkg::otc_transport_ev_t transport_ev,
	input  wire otc_pkg::otc_path_ev_t      path_ev,
	input  wire logic                       aps_port_valid,
	output logic                            hw_irq,
	output logic                            transport_irq,
	output logic                            path_irq,
	output otc_pkg::otc_ctrl_t              ctrl
);

	otc_pkg::otc_state_t s_q;
	otc_pkg::otc_state_t s_d;

	// Source of a group: port or terminal, forced to port in payload-only mode
	function automatic otc_pkg::otc_src_t port_src(input logic sel, input logic payload_only);
		port_src = (sel || payload_only) ? otc_pkg::OTC_SRC_PORT : otc_pkg::OTC_SRC_TERMINAL; // R22
	endfunction

	// Source of a group: RAM or terminal, forced to RAM in payload-only mode
	function automatic otc_pkg::otc_src_t ram_src(input logic sel, input logic payload_only);
		ram_src = (sel || payload_only) ? otc_pkg::OTC_SRC_RAM : otc_pkg::OTC_SRC_TERMINAL; // R22
	endfunction

	// Edge detection on an alarm vector
	function automatic logic edge_hit(input logic [16:0] cur, input logic [16:0] prev, input logic both);
		edge_hit = both ? |(cur ^ prev) : |(cur & ~prev); // R13
	endfunction

	logic        wr_acc;
	logic        rd_acc;
	logic        mapped;
	logic [16:0] tvec;
	logic [16:0] tprev;
	logic [16:0] pvec;
	logic [16:0] pprev;
	logic        pay_only;

	// Next-state logic
	always_comb begin
		s_d    = s_q;
		wr_acc = psel && penable && pwrite;
		rd_acc = psel && !penable && !pwrite;
		mapped = (paddr == `OTC_ADDR_LINE_MODE) || (paddr == `OTC_ADDR_TX_OH_SRC) ||
			(paddr == `OTC_ADDR_PAYLOAD_MODE) || (paddr == `OTC_ADDR_ALARM_STATUS);

		// APB: no wait state, answer in first access cycle
		s_d.pready  = psel && !penable;
		s_d.pslverr = psel && !penable && !mapped;

		// Register writes, byte lane 0 carries the data
		if (wr_acc && pstrb[0]) begin
			if (paddr == `OTC_ADDR_LINE_MODE) begin
				s_d.line_mode = pwdata[7:0]; // R25
			end else if (paddr == `OTC_ADDR_TX_OH_SRC) begin
				s_d.tx_src = pwdata[7:0]; // R25
			end else if (paddr == `OTC_ADDR_PAYLOAD_MODE) begin
				s_d.payload = pwdata[7:0];
				if (pwdata[`OTC_B_RX_RETIME]) begin
					s_d.payload[`OTC_B_PAYLOAD_ONLY] = 1'b0; // R24
				end
			end
		end

		// Read data captured in setup phase
		s_d.prdata = 32'h0000_0000;
		if (rd_acc) begin
			if (paddr == `OTC_ADDR_LINE_MODE) begin
				s_d.prdata = {24'h00_0000, s_q.line_mode}; // R25
			end else if (paddr == `OTC_ADDR_TX_OH_SRC) begin
				s_d.prdata = {24'h00_0000, s_q.tx_src}; // R25
			end else if (paddr == `OTC_ADDR_PAYLOAD_MODE) begin
				s_d.prdata = {24'h00_0000, s_q.payload};
			end else if (paddr == `OTC_ADDR_ALARM_STATUS) begin
				s_d.prdata = {24'h00_0000, 2'h0, s_q.trans_pend, s_q.path_pend, s_q.los_s2,
					s_q.irq, s_q.trans_irq, s_q.path_irq};
			end
		end

		// Two-flop synchronisers on event inputs
		s_d.trans_s1   = transport_ev;
		s_d.trans_s2   = s_q.trans_s1;
		s_d.trans_prev = s_q.trans_s2;
		s_d.path_s1    = path_ev;
		s_d.path_s2    = s_q.path_s1;
		s_d.path_prev  = s_q.path_s2;
		s_d.los_s1     = aps_port_valid;
		s_d.los_s2     = s_q.los_s1;

		// Edge detection; set wins over clear by status read
		tvec  = s_q.trans_s2;
		tprev = s_q.trans_prev;
		pvec  = {8'h00, s_q.path_s2};
		pprev = {8'h00, s_q.path_prev};
		if (rd_acc && paddr == `OTC_ADDR_ALARM_STATUS) begin
			s_d.trans_pend = 1'b0;
			s_d.path_pend  = 1'b0;
		end
		if (edge_hit(tvec, tprev, s_q.line_mode[`OTC_B_BOTH_EDGES])) begin
			s_d.trans_pend = 1'b1; // R09 R10
		end
		if (edge_hit(pvec, pprev, s_q.line_mode[`OTC_B_BOTH_EDGES])) begin
			s_d.path_pend = 1'b1; // R12
		end

		// Interrupt gating by enables
		s_d.trans_irq = s_q.trans_pend && s_q.line_mode[`OTC_B_TRANS_IRQ_EN]; // R08
		s_d.path_irq  = s_q.path_pend && s_q.line_mode[`OTC_B_PATH_IRQ_EN]; // R11
		s_d.irq       = s_q.line_mode[`OTC_B_HW_IRQ_EN] && (s_q.trans_irq || s_q.path_irq); // R04

		// Decoded datapath controls
		pay_only                     = s_q.payload[`OTC_B_PAYLOAD_ONLY];
		s_d.ctrl.scramble_en         = s_q.line_mode[`OTC_B_LINE_RATE]; // R01 R02
		s_d.ctrl.b1_recalc           = s_q.line_mode[`OTC_B_LINE_RATE]; // R01
		s_d.ctrl.b1_error_mask       = !s_q.line_mode[`OTC_B_LINE_RATE]; // R02
		s_d.ctrl.terminal_parallel   = s_q.line_mode[`OTC_B_TERM_PAR]; // R03
		s_d.ctrl.rx_serial_active    = 1'b1; // R03
		s_d.ctrl.ferf_insert         = s_q.line_mode[`OTC_B_RFI_INS_EN] &&
			(s_q.trans_s2.rx_loss_signal || s_q.trans_s2.rx_loss_frame ||
			s_q.trans_s2.rx_line_alarm_ind); // R05 R06
		s_d.ctrl.alt_orderwire_frame = s_q.line_mode[`OTC_B_ALT_OW]; // R07
		s_d.ctrl.sdcc_src            = port_src(s_q.tx_src[`OTC_B_SDCC_PORT], pay_only); // R14
		s_d.ctrl.ldcc_src            = port_src(s_q.tx_src[`OTC_B_LDCC_PORT], pay_only); // R15
		s_d.ctrl.sow_src             = port_src(s_q.tx_src[`OTC_B_SOW_PORT], pay_only); // R16
		s_d.ctrl.low_src             = port_src(s_q.tx_src[`OTC_B_LOW_PORT], pay_only); // R17
		s_d.ctrl.path_src            = s_q.tx_src[`OTC_B_PATH_RAM] ? otc_pkg::OTC_SRC_RAM
			: otc_pkg::OTC_SRC_TERMINAL; // R18
		s_d.ctrl.h4_from_terminal    = 1'b1; // R18
		// APS: RAM, else port when capturing or payload-only, else terminal
		if (s_q.tx_src[`OTC_B_APS_RAM]) begin
			s_d.ctrl.aps_src = otc_pkg::OTC_SRC_RAM; // R19 R23
		end else if (s_q.tx_src[`OTC_B_APS_CAPTURE] || pay_only) begin
			s_d.ctrl.aps_src = otc_pkg::OTC_SRC_PORT; // R22 R23
		end else begin
			s_d.ctrl.aps_src = otc_pkg::OTC_SRC_TERMINAL; // R19
		end
		s_d.ctrl.aps_capture         = s_q.tx_src[`OTC_B_APS_CAPTURE] && s_q.los_s2; // R20
		s_d.ctrl.rx_to_tx_loopback   = s_q.tx_src[`OTC_B_LOOPBACK]; // R21
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q           <= '0;
			s_q.line_mode <= `OTC_RST_LINE_MODE;
			s_q.tx_src    <= `OTC_RST_TX_OH_SRC;
			s_q.payload   <= `OTC_RST_PAYLOAD_MODE;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign pready        = s_q.pready;
	assign pslverr       = s_q.pslverr;
	assign prdata        = s_q.prdata;
	assign hw_irq        = s_q.irq;
	assign transport_irq = s_q.trans_irq;
	assign path_irq      = s_q.path_irq;
	assign ctrl          = s_q.ctrl;

endmodule

`default_nettype wire

// ===== sim/otc_ctrl_regs_monitor.sv
// Checker for the control register bank, bound to its ports.
// Assumes one clock domain and the register header on the path.
`include "otc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module otc_ctrl_regs_monitor (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic [11:0]                paddr,
	input wire logic                       pready,
	input wire logic                       pslverr,
	input wire logic [31:0]                prdata,
	input wire otc_pkg::otc_transport_ev_t transport_ev,
	input wire logic                       hw_irq,
	input wire logic                       transport_irq,
	input wire logic                       path_irq,
	input wire otc_pkg::otc_ctrl_t         ctrl
);
	wire logic fa;
	// Alarms that call for remote failure insertion
	assign fa = transport_ev.rx_loss_signal | transport_ev.rx_loss_frame | transport_ev.rx_line_alarm_ind;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Setup and answered access phases
	sequence s_set;
		psel && !penable;
	endsequence
	sequence s_acc;
		psel && penable && pready;
	endsequence
	AST_READY: assert property (s_set |=> s_acc)
		else $error("no answer in first access cycle");
	AST_UNMAP: assert property (s_set ##0 (paddr == 12'h004) |=> s_acc ##0 (pslverr && prdata == 32'h0))
		else $error("unmapped access not refused");
	AST_MAPPED: assert property (s_set ##0 (paddr == `OTC_ADDR_LINE_MODE) |=> !pslverr)
		else $error("mapped access refused");
	AST_RDHI: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("read data above byte not zero");
	AST_SCR: assert property (ctrl.scramble_en |-> ctrl.b1_recalc && !ctrl.b1_error_mask)
		else $error("line rate decode wrong");
	AST_PAR: assert property (ctrl.terminal_parallel |-> ctrl.rx_serial_active)
		else $error("serial receive dropped in parallel mode");
	AST_HW: assert property (hw_irq |-> $past(transport_irq || path_irq))
		else $error("hardware interrupt without cause");
	AST_APS: assert property (ctrl.aps_src != 2'h3)
		else $error("aps source outside three choices");
	AST_FERF: assert property (ctrl.ferf_insert |-> $past(fa, 2) || $past(fa, 3) || $past(fa, 4))
		else $error("remote failure inserted without alarm");
endmodule
bind otc_ctrl_regs otc_ctrl_regs_monitor u_otc_ctrl_regs_monitor (.pclk, .presetn, .psel, .penable, .paddr,
	.pready, .pslverr, .prdata, .transport_ev, .hw_irq, .transport_irq, .path_irq, .ctrl);
`default_nettype wire

// ===== sim/test_otc_ctrl_regs.sv
// Self-checking bench for the control register bank.
// Assumes design, package and checker are compiled first.
`include "otc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_otc_ctrl_regs;
	logic                       pclk, presetn, psel, penable, pwrite, pready, pslverr, er, fa;
	logic                       hw_irq, transport_irq, path_irq, apv;
	logic [11:0]                paddr;
	logic [31:0]                pwdata, prdata, rd;
	logic [3:0]                 pstrb;
	logic [7:0]                 lm, ts, pm;
	otc_pkg::otc_transport_ev_t tev;
	otc_pkg::otc_path_ev_t      pev;
	otc_pkg::otc_ctrl_t         ctrl;
	int                         n_errors, checked, seed;
	otc_ctrl_regs u_otc_ctrl_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
		.pready, .pslverr, .prdata, .transport_ev(tev), .path_ev(pev), .aps_port_valid(apv),
		.hw_irq, .transport_irq, .path_irq, .ctrl);
	// Clock, 40 ns period
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Verdict and end of run
	task test_done();
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Comparisons of read data, decoded controls and interrupt levels
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task chk_rd(input logic [31:0] g, input logic [31:0] e);
		chk(g, e);
	endtask
	task chk_ctl(input otc_pkg::otc_ctrl_t g, input otc_pkg::otc_ctrl_t e);
		chk(32'(g), 32'(e));
	endtask
	task chk_irq(input logic [2:0] e);
		repeat (8) @(posedge pclk);
		chk({29'h0, hw_irq, transport_irq, path_irq}, {29'h0, e});
	endtask
	// One APB transfer, waiting for pready under a bound
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		int i;
		int r;
		r = $random(seed);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {r[31:8], d};
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			n_errors++;
			test_done();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Write that also updates the model
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
		if (a == `OTC_ADDR_LINE_MODE) lm = d;
		if (a == `OTC_ADDR_TX_OH_SRC) ts = d;
		if (a == `OTC_ADDR_PAYLOAD_MODE) pm = d[1] ? d & 8'h7f : d;
		repeat (3) @(posedge pclk);
	endtask
	function automatic otc_pkg::otc_src_t sp(input logic b);
		return b ? otc_pkg::OTC_SRC_PORT : otc_pkg::OTC_SRC_TERMINAL;
	endfunction
	// Expected decoded controls from the model registers
	function automatic otc_pkg::otc_ctrl_t ex();
		logic p;
		p = pm[7];
		return '{lm[7], lm[7], !lm[7], lm[6], 1'b1, lm[4] & fa, lm[3], sp(ts[7] | p), sp(ts[6] | p),
			sp(ts[5] | p), sp(ts[4] | p), ts[3] ? otc_pkg::OTC_SRC_RAM : otc_pkg::OTC_SRC_TERMINAL,
			ts[2] ? otc_pkg::OTC_SRC_RAM : sp(ts[1] | p), 1'b1, ts[1] & apv, ts[0]};
	endfunction
	// Main sequence
	initial begin
		seed = 26;
		{presetn, psel, penable, pwrite, paddr, pwdata, tev, pev, lm, ts, pm, fa, apv} = '0;
		pstrb = 4'hf;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, `OTC_ADDR_LINE_MODE, 8'h00);
		chk_rd(rd, {24'h0, `OTC_RST_LINE_MODE});
		apb(1'b0, `OTC_ADDR_TX_OH_SRC, 8'h00);
		chk_rd(rd, {24'h0, `OTC_RST_TX_OH_SRC});
		for (int k = 0; k < 24; k++) begin
			apv <= k[0];
			if (k == 12) wr(`OTC_ADDR_PAYLOAD_MODE, 8'h80);
			wr(`OTC_ADDR_LINE_MODE, 8'($random(seed)));
			wr(`OTC_ADDR_TX_OH_SRC, 8'($random(seed)));
			chk_ctl(ctrl, ex());
			apb(1'b0, `OTC_ADDR_LINE_MODE, 8'h00);
			chk_rd(rd, {24'h0, lm});
			apb(1'b0, `OTC_ADDR_TX_OH_SRC, 8'h00);
			chk_rd(rd, {24'h0, ts});
		end
		apv <= 1'b0;
		wr(`OTC_ADDR_PAYLOAD_MODE, 8'h82);
		chk_ctl(ctrl, ex());
		apb(1'b0, `OTC_ADDR_PAYLOAD_MODE, 8'h00);
		chk_rd(rd & 32'h80, 32'h0);
		apb(1'b0, 12'h004, 8'h00);
		chk_rd({er, rd[30:0]}, 32'h80000000);
		pstrb <= 4'h0;
		apb(1'b1, `OTC_ADDR_LINE_MODE, ~lm);
		pstrb <= 4'hf;
		apb(1'b0, `OTC_ADDR_LINE_MODE, 8'h00);
		chk_rd(rd, {24'h0, lm});
		$display("test registers done");
		wr(`OTC_ADDR_LINE_MODE, 8'h34);
		tev.rx_loss_signal <= 1'b1;
		fa = 1'b1;
		chk_irq(3'b110);
		chk_ctl(ctrl, ex());
		apb(1'b0, `OTC_ADDR_ALARM_STATUS, 8'h00);
		chk_rd(rd, 32'h26);
		tev.rx_loss_signal <= 1'b0;
		fa = 1'b0;
		chk_irq(3'b000);
		wr(`OTC_ADDR_LINE_MODE, 8'h35);
		tev.b1b2_overflow[2] <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(1'b0, `OTC_ADDR_ALARM_STATUS, 8'h00);
		tev.b1b2_overflow[2] <= 1'b0;
		chk_irq(3'b110);
		wr(`OTC_ADDR_LINE_MODE, 8'h22);
		pev.path_yellow <= 1'b1;
		chk_irq(3'b101);
		apb(1'b0, `OTC_ADDR_ALARM_STATUS, 8'h00);
		wr(`OTC_ADDR_LINE_MODE, 8'h20);
		pev.new_poh_byte[0] <= 1'b1;
		chk_irq(3'b000);
		$display("test interrupts done");
		test_done();
	end
endmodule
`default_nettype wire
